// [scm_spi.sv]
/*
  scm_spi: serial clock mode and transfer enable framing, master or slave.
  assumes: pins come from outside the core clock domain; the serial clock
  in slave mode is well below the core clock (about 800 ns period).
*/
// Overview of operation
// RULE1: mode 0/0 idles low, rising-edge data
// RULE2: mode 0/1 idles low, half-cycle early
// RULE3: mode 1/0 idles high, falling-edge data
// RULE4: mode 1/1 idles high, half-cycle early
// RULE5: master holds enable asserted whole word
// RULE6: remote master holds enable whole word
// RULE7: invert setting makes enable active high
`timescale 1ns/1ns
`default_nettype none
module scm_spi
  import scm_pkg::*;
#(
  parameter int WORD_BITS = SCM_WORD_BITS,
  parameter int FIFO_DEPTH = SCM_FIFO_DEPTH
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // configuration levels
  input wire logic master_mode_in,
  input wire logic clock_polarity_in,
  input wire logic clock_phase_in,
  input wire logic enable_polarity_invert_in,
  // transmit word stream
  input wire logic tx_valid_in,
  input wire logic [WORD_BITS-1:0] tx_data_in,
  output logic tx_ready_out,
  // received word stream
  output logic rx_valid_out,
  output logic [WORD_BITS-1:0] rx_data_out,
  // serial clock pin, three signals
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  // transfer enable pin, three signals
  input wire logic transfer_enable_n_in,
  output logic transfer_enable_n_out,
  output logic transfer_enable_n_oe_out,
  // data pins
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  // status
  output logic busy_out
);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam int HW = $clog2(SCM_HALF_CYCLES + 1);

  scm_state_t state;
  scm_state_t next_state;
  logic [1:0] sclk_sync;
  logic [1:0] en_sync;
  logic [1:0] din_sync;
  logic sclk_prev;
  logic en_prev;
  logic [WORD_BITS-1:0] shift;
  logic [CW-1:0] bit_cnt;
  logic [HW-1:0] half_cnt;
  logic sclk_int;
  logic fifo_valid;
  logic [WORD_BITS-1:0] fifo_data;
  logic [WORD_BITS-1:0] rx_shift;
  logic fifo_pop;

  scm_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(tx_valid_in),
    .in_data_in(tx_data_in),
    .in_ready_out(tx_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  // the first stage of each synchroniser is read only by the second
  always_ff @(posedge core_clk_in)
  begin
    sclk_sync <= {sclk_sync[0], serial_clock_pin_in};
    en_sync <= {en_sync[0], transfer_enable_n_in};
    din_sync <= {din_sync[0], serial_data_in};
  end

  wire sclk_s = sclk_sync[1];
  wire en_raw = en_sync[1];
  // RULE7: enable sense follows invert setting
  wire slave_sel = enable_polarity_invert_in ? en_raw : !en_raw;
  wire slave_sel_prev = enable_polarity_invert_in ? en_prev : !en_prev;
  // RULE1: leading edge away from idle level
  wire sclk_rise = sclk_s && !sclk_prev;
  wire sclk_fall = !sclk_s && sclk_prev;
  // RULE3: polarity 1 swaps leading edge
  wire lead_edge = clock_polarity_in ? sclk_fall : sclk_rise;
  wire trail_edge = clock_polarity_in ? sclk_rise : sclk_fall;
  // RULE2: phase 0 changes on leading, phase 1 half early
  wire samp_edge = clock_phase_in ? lead_edge : trail_edge;
  wire chg_edge = clock_phase_in ? trail_edge : lead_edge;

  wire half_done = (half_cnt == HW'(SCM_HALF_CYCLES - 1));
  wire m_lead = master_mode_in && (state == SCM_SHIFT) && half_done && !sclk_int;
  wire m_trail = master_mode_in && (state == SCM_SHIFT) && half_done && sclk_int;
  wire do_sample = master_mode_in ? (clock_phase_in ? m_lead : m_trail)
                                  : (state == SCM_SHIFT && samp_edge);
  wire do_change = master_mode_in ? (clock_phase_in ? m_trail : m_lead)
                                  : (state == SCM_SHIFT && chg_edge);
  wire last_bit = (bit_cnt == CW'(WORD_BITS - 1));
  wire word_end = do_sample && last_bit;
  // phase 0 keeps the preloaded msb through the first leading edge
  wire tx_adv = do_change && (clock_phase_in || bit_cnt != '0);
  // frame ends on the 16th trailing edge in both phases
  wire word_over = clock_phase_in ? (bit_cnt == CW'(WORD_BITS)) : last_bit;
  wire start_m = master_mode_in && fifo_valid && state == SCM_IDLE;
  wire start_s = !master_mode_in && state == SCM_IDLE && slave_sel && !slave_sel_prev;
  assign fifo_pop = (start_m || start_s) && fifo_valid;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SCM_IDLE:
      begin
        if (start_m || start_s)
        begin
          next_state = master_mode_in ? SCM_LEAD : SCM_SHIFT;
        end
      end
      SCM_LEAD:
      begin
        if (half_done)
        begin
          next_state = SCM_SHIFT;
        end
      end
      SCM_SHIFT:
      begin
        if (!master_mode_in && !slave_sel)
        begin
          next_state = SCM_IDLE;
        end
        else if (master_mode_in && half_done && sclk_int && word_over)
        begin
          next_state = SCM_DONE;
        end
      end
      SCM_DONE:
      begin
        if (master_mode_in ? half_done : !slave_sel)
        begin
          next_state = SCM_IDLE;
        end
      end
      default:
      begin
        next_state = SCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      state <= SCM_IDLE;
      sclk_prev <= 1'b0;
      en_prev <= 1'b1;
      half_cnt <= '0;
      sclk_int <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sclk_prev <= sclk_s;
      en_prev <= en_raw;
      half_cnt <= (state == SCM_IDLE || half_done) ? '0 : half_cnt + 1'b1;
      // sclk_int is the active-phase marker, polarity applied at the pin
      if (state != SCM_SHIFT)
      begin
        sclk_int <= 1'b0;
      end
      else if (half_done && master_mode_in)
      begin
        sclk_int <= !sclk_int;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      shift <= '0;
      rx_shift <= '0;
      bit_cnt <= '0;
      rx_valid_out <= 1'b0;
      rx_data_out <= '0;
    end
    else
    begin
      rx_valid_out <= 1'b0;
      if (fifo_pop || start_s)
      begin
        shift <= fifo_valid ? fifo_data : '0;
        bit_cnt <= '0;
      end
      else
      begin
        // transmit advances on change edges, receive fills on sample edges
        if (tx_adv)
        begin
          shift <= {shift[WORD_BITS-2:0], 1'b0};
        end
        if (do_sample)
        begin
          rx_shift <= {rx_shift[WORD_BITS-2:0], din_sync[1]};
          bit_cnt <= bit_cnt + 1'b1;
          if (word_end)
          begin
            rx_valid_out <= 1'b1;
            rx_data_out <= {rx_shift[WORD_BITS-2:0], din_sync[1]};
          end
        end
      end
    end
  end

  // data output: msb leads; phase 0 presents it before first edge
  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_out <= 1'b0;
      transfer_enable_n_out <= 1'b1;
      transfer_enable_n_oe_out <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe_out <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      // RULE4: idle level equals polarity
      serial_clock_pin_out <= clock_polarity_in ^ sclk_int;
      serial_clock_pin_oe_out <= master_mode_in;
      // RULE5: enable asserted from lead-in to end of word
      transfer_enable_n_out <= (state == SCM_IDLE) ^ enable_polarity_invert_in;
      transfer_enable_n_oe_out <= master_mode_in;
      serial_data_out <= shift[WORD_BITS-1];
      // RULE6: slave drives data only while selected
      serial_data_oe_out <= master_mode_in || (state != SCM_IDLE && slave_sel);
      busy_out <= (state != SCM_IDLE);
    end
  end
endmodule
`default_nettype wire

// [scm_pkg.sv]
/*
  scm_pkg: constants shared by the serial clock mode and enable framing block.
  assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package scm_pkg;
  localparam int SCM_WORD_BITS = 16;
  localparam int SCM_FIFO_DEPTH = 4;
  localparam int SCM_CORE_CLK_NS = 100;
  // half serial period in ns when master (clock divider)
  localparam int SCM_HALF_PERIOD_NS = 400;
  localparam int SCM_HALF_CYCLES = (SCM_HALF_PERIOD_NS + SCM_CORE_CLK_NS - 1) / SCM_CORE_CLK_NS;
  localparam int SCM_SYNC_STAGES = 2;
  localparam logic [1:0] SCM_MODE_P0_PH0 = 2'h0;
  localparam logic [1:0] SCM_MODE_P0_PH1 = 2'h1;
  localparam logic [1:0] SCM_MODE_P1_PH0 = 2'h2;
  localparam logic [1:0] SCM_MODE_P1_PH1 = 2'h3;
  typedef enum logic [3:0] {
    SCM_IDLE = 4'h1,
    SCM_LEAD = 4'h2,
    SCM_SHIFT = 4'h4,
    SCM_DONE = 4'h8
  } scm_state_t;
endpackage
`default_nettype wire

// [scm_fifo.sv]
/*
  scm_fifo: small synchronous fifo with valid/ready on both sides.
  assumes: one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  // ready is registered from the next count so it leaves the block from a flop
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
    end
    else
    begin
      // depth must be a power of two so pointers wrap naturally
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready_out <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule
`default_nettype wire

// [scm_spi_asserts.sv]
/*
  scm_spi_asserts: port checks for scm_spi, bound below.
  assumes: one core clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_spi_asserts
#(
  parameter int WORD_BITS = 16
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic master_mode_in,
  input wire logic clock_polarity_in,
  input wire logic enable_polarity_invert_in,
  input wire logic rx_valid_out,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_out,
  input wire logic transfer_enable_n_in,
  input wire logic transfer_enable_n_out,
  input wire logic transfer_enable_n_oe_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [4:0] cfg_q;
  logic [4:0] cfg_qq;
  logic [7:0] edges;
  logic clk_q;
  // calm: settings and busy unchanged for two cycles, so outputs have caught up
  wire logic calm = (cfg_q == {master_mode_in, clock_polarity_in,
    enable_polarity_invert_in, busy_out, 1'b1}) && (cfg_qq == cfg_q);
  wire logic toggled = clk_q != serial_clock_pin_out;
  always_ff @(posedge core_clk_in)
  begin
    cfg_q <= {master_mode_in, clock_polarity_in, enable_polarity_invert_in, busy_out, nrst_in};
    cfg_qq <= cfg_q;
    clk_q <= serial_clock_pin_out;
    edges <= (!nrst_in || !busy_out) ? 8'h00 : edges + {7'h00, toggled};
  end
  AST_CLK_IDLE:
    assert property (master_mode_in && !busy_out && calm |-> serial_clock_pin_out == clock_polarity_in)
      else $error("clock not at idle level");
  AST_EN_HELD:
    assert property (master_mode_in && busy_out && calm |-> transfer_enable_n_out == enable_polarity_invert_in)
      else $error("enable dropped in frame");
  AST_EN_IDLE:
    assert property (master_mode_in && !busy_out && calm |-> transfer_enable_n_out != enable_polarity_invert_in)
      else $error("enable active while idle");
  AST_PIN_DRIVE:
    assert property (calm |-> serial_clock_pin_oe_out == master_mode_in && transfer_enable_n_oe_out == master_mode_in)
      else $error("pin drive wrong for mode");
  AST_CLK_FRAMED:
    assert property (master_mode_in && calm && toggled |-> transfer_enable_n_out == enable_polarity_invert_in)
      else $error("clock edge outside enable");
  AST_HALF_PERIOD:
    assert property (master_mode_in && busy_out && toggled |=> $stable(serial_clock_pin_out)[*3])
      else $error("half period too short");
  AST_EDGE_COUNT:
    assert property (master_mode_in && $fell(busy_out) |-> edges == 8'(2 * WORD_BITS))
      else $error("wrong clock edge count");
  AST_RX_FRAMED:
    assert property (rx_valid_out && !master_mode_in |-> $past(transfer_enable_n_in, 2) == enable_polarity_invert_in)
      else $error("word without enable");
  cover property (master_mode_in && $fell(busy_out) && clock_polarity_in);
  cover property (!master_mode_in && rx_valid_out && enable_polarity_invert_in);
  cover property (master_mode_in && busy_out && toggled);
endmodule
bind scm_spi scm_spi_asserts #(.WORD_BITS(WORD_BITS)) chk_u (.*);
`default_nettype wire

// [scm_far_master.sv]
/*
  scm_far_master: remote master driving clock and enable at 800 ns period.
  assumes: called by task from the bench; clock stands still between frames.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_far_master
(
  input wire logic pol_in,
  input wire logic pha_in,
  input wire logic inv_in,
  input wire logic sdi_in,
  output logic sclk_out,
  output logic en_out,
  output var logic sdo_out = 1'b0
);
  logic lead = 1'b0;
  logic act = 1'b0;
  assign sclk_out = pol_in ^ lead;
  assign en_out = act ? inv_in : !inv_in;
  task automatic xfer(input logic [15:0] w, output logic [15:0] got);
    integer i;
    act = 1'b1;
    for (i = 15; i >= 0; i--)
    begin
      if (pha_in) sdo_out = w[i];
      #400 lead = 1'b1;
      if (pha_in) got[i] = sdi_in;
      else sdo_out = w[i];
      #400 if (!pha_in) got[i] = sdi_in;
      lead = 1'b0;
    end
    #400 act = 1'b0;
    // released line: no stale bit left behind
    sdo_out = !sdo_out;
  endtask
endmodule
`default_nettype wire

// [scm_spi_bench.sv]
/*
  scm_spi_bench: slave frames in all modes, then master loopback with fifo fill.
  assumes: scm_spi, scm_fifo, scm_far_master and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_spi_bench;
  import scm_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic master_mode_in = 1'b0;
  logic clock_polarity_in = 1'b0;
  logic clock_phase_in = 1'b0;
  logic enable_polarity_invert_in = 1'b0;
  logic tx_valid_in = 1'b0;
  logic [15:0] tx_data_in = 16'h0000;
  logic tx_ready_out, rx_valid_out, serial_clock_pin_out, serial_clock_pin_oe_out;
  logic [15:0] rx_data_out;
  logic transfer_enable_n_out, transfer_enable_n_oe_out, serial_data_out, serial_data_oe_out;
  logic busy_out, p_clk, p_en, p_sdo;
  wire logic serial_clock_pin_in, transfer_enable_n_in, serial_data_in, p_sdi;
  integer seed, m, k, bad_count = 0, n_tests = 0;
  logic [15:0] w, pw, got, txq[$], rxq[$];
  // each pin resolved from whoever drives it; master data loops back
  assign serial_clock_pin_in = serial_clock_pin_oe_out ? serial_clock_pin_out : p_clk;
  assign transfer_enable_n_in = transfer_enable_n_oe_out ? transfer_enable_n_out : p_en;
  assign serial_data_in = master_mode_in ? serial_data_out : p_sdo;
  assign p_sdi = serial_data_oe_out ? serial_data_out : !serial_data_out;
  scm_spi dut_u (.*);
  scm_far_master far_u (.pol_in(clock_polarity_in), .pha_in(clock_phase_in),
    .inv_in(enable_polarity_invert_in), .sdi_in(p_sdi), .sclk_out(p_clk),
    .en_out(p_en), .sdo_out(p_sdo));
  initial forever #50 core_clk_in = !core_clk_in;
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic limit_check(input integer n);
    if (n >= 3000)
    begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic push(input logic [15:0] v);
    @(posedge core_clk_in);
    tx_valid_in <= 1'b1;
    tx_data_in <= v;
    @(negedge core_clk_in);
    for (k = 0; k < 3000 && tx_ready_out !== 1'b1; k++)
      @(negedge core_clk_in);
    limit_check(k);
    @(posedge core_clk_in);
    tx_valid_in <= 1'b0;
    if (master_mode_in) rxq.push_back(v);
    else txq.push_back(v);
  endtask
  always @(negedge core_clk_in)
    if (rx_valid_out === 1'b1)
      check(rx_data_out, rxq.size() ? rxq.pop_front() : 16'hXXXX);
  initial
  begin
    seed = 32'hA00ACFFA;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    for (m = 0; m < 16; m++)
    begin
      @(posedge core_clk_in);
      {master_mode_in, enable_polarity_invert_in, clock_polarity_in, clock_phase_in} <= m[3:0];
      if (m < 8)
      begin
        // one frame with nothing queued: device must send zeros
        w = 16'($random(seed));
        if (m != 5) push(w);
        pw = 16'($random(seed));
        rxq.push_back(pw);
        #37;
        far_u.xfer(pw, got);
        check(got, txq.size() ? txq.pop_front() : 16'h0000);
      end
      else
      begin
        repeat (5) push(16'($random(seed)));
        @(negedge core_clk_in);
        check(16'(tx_ready_out), 16'(SCM_FIFO_DEPTH > 4));
      end
      for (k = 0; k < 3000 && (rxq.size() != 0 || busy_out !== 1'b0); k++)
        @(negedge core_clk_in);
      limit_check(k);
    end
    stop_test();
  end
endmodule
`default_nettype wire
